/* File: logic/adcbi_pkg.sv */
// Notes on behaviour
// - Selected means select high and enable_n low; it gates both strobes.
// - In demand mode a selected low convert_strobe_n starts a conversion.
// - Selected with output_enable_n low drives the bus, else it is released.
// - The result bus is eight three-state lines, the top one separate.
// - High run_mode_select converts back to back, low waits for the strobe.
// - In demand mode byte_half_select picks the low or high result byte.
// - On high-byte demand reads flag_byte_select picks overrange or polarity.
// - The top line carries polarity, overrange or the top data bit.
// - Busy rises as de-integration starts and falls once it completes.
// - Conversion timing comes from the internal divider or clock_in_pin.
package adcbi_pkg;
   localparam int unsigned ADCBI_CLK_HZ = 50_000_000;
   localparam int unsigned ADCBI_OSC_HZ = 61_440;
   localparam int unsigned ADCBI_OSC_DIV = ADCBI_CLK_HZ / ADCBI_OSC_HZ;
   localparam int unsigned ADCBI_INTEG_TICKS = 4000;
   localparam int unsigned ADCBI_DEINT_MAX = 8192;
   localparam int unsigned ADCBI_TICK_W = 16;

   // Word byte addresses on the register bus.
   localparam logic [7:0] ADCBI_A_CTRL = 8'h00;
   localparam logic [7:0] ADCBI_A_STAT = 8'h04;
   localparam logic [7:0] ADCBI_A_MASK = 8'h08;
   localparam logic [7:0] ADCBI_A_RSLT = 8'h0C;
   localparam logic [7:0] ADCBI_A_INTG = 8'h10;

   // Control register fields.
   localparam int unsigned ADCBI_CTRL_EXTCLK = 0;
   localparam logic [31:0] ADCBI_CTRL_RST = 32'h0000_0000;

   // Status and mask fields.
   localparam int unsigned ADCBI_ST_DONE = 0;
   localparam int unsigned ADCBI_ST_START = 1;
   localparam int unsigned ADCBI_ST_OVR = 2;
   localparam int unsigned ADCBI_ST_W = 3;
   localparam logic [2:0] ADCBI_MASK_RST = 3'h0;

   // Result register fields.
   localparam int unsigned ADCBI_RS_POL = 15;
   localparam int unsigned ADCBI_RS_OVR = 16;
   localparam int unsigned ADCBI_RS_BUSY = 31;

   // Pin vector positions after synchronisation.
   localparam int unsigned ADCBI_P_SEL = 0;
   localparam int unsigned ADCBI_P_EN_N = 1;
   localparam int unsigned ADCBI_P_CONV_N = 2;
   localparam int unsigned ADCBI_P_OE_N = 3;
   localparam int unsigned ADCBI_P_RUN = 4;
   localparam int unsigned ADCBI_P_FLAG = 5;
   localparam int unsigned ADCBI_P_BYTE = 6;
   localparam int unsigned ADCBI_P_OSC = 7;
   localparam int unsigned ADCBI_P_W = 8;
   // Idle pin levels: enable_n and both strobes high, everything else low.
   localparam logic [7:0] ADCBI_PIN_IDLE = 8'h0E;

   typedef enum logic [1:0] {
      ADCBI_IDLE,
      ADCBI_INTEG,
      ADCBI_DEINT
   } adcbi_state_t;
endpackage

/* File: logic/adcbi_sync_if.sv */
`timescale 1ns/1ns
interface adcbi_sync_if #(parameter int unsigned W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface

/* File: logic/adcbi_sync2.sv */
`timescale 1ns/1ns
module adcbi_sync2
   import adcbi_pkg::*;
#(
   parameter int unsigned W = 8,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   adcbi_sync_if.dst p
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end
      else
      begin
         meta_r <= p.raw;
         sync_r <= meta_r;
      end
   end

   assign p.sync = sync_r;
endmodule

/* File: logic/adcbi_top.sv */
`timescale 1ns/1ns
module adcbi_top
   import adcbi_pkg::*;
#(
   parameter int unsigned OSC_DIV = ADCBI_OSC_DIV,
   parameter int unsigned INTEG_TICKS = ADCBI_INTEG_TICKS,
   parameter int unsigned DEINT_MAX = ADCBI_DEINT_MAX
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Host pins.
   input wire logic chip_select_i,
   input wire logic enable_active_low_n_i,
   input wire logic convert_strobe_n_i,
   input wire logic output_enable_n_i,
   input wire logic run_mode_select_i,
   input wire logic flag_byte_select_i,
   input wire logic byte_half_select_i,
   input wire logic clock_in_pin_i,
   output logic [6:0] result_bus_o,
   output logic result_bus_oe_o,
   output logic result_bus_msb_o,
   output logic result_bus_msb_oe_o,
   output logic busy_o,
   // Analog core, same clock.
   output logic core_integrate_o,
   output logic core_deintegrate_o,
   input wire logic core_zero_cross_i,
   input wire logic [14:0] core_magnitude_i,
   input wire logic core_polarity_i,
   input wire logic core_overrange_i
);
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (OSC_DIV < 2 || OSC_DIV >= (1 << ADCBI_TICK_W))
   begin : g_bad_div
      $error("OSC_DIV out of range");
   end
   if (INTEG_TICKS < 1 || INTEG_TICKS >= (1 << ADCBI_TICK_W))
   begin : g_bad_integ
      $error("INTEG_TICKS out of range");
   end
   if (DEINT_MAX < 1 || DEINT_MAX >= (1 << ADCBI_TICK_W))
   begin : g_bad_deint
      $error("DEINT_MAX out of range");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   adcbi_sync_if #(.W(ADCBI_P_W)) pins ();

   assign pins.raw = {clock_in_pin_i, byte_half_select_i,
      flag_byte_select_i, run_mode_select_i, output_enable_n_i,
      convert_strobe_n_i, enable_active_low_n_i, chip_select_i};

   adcbi_sync2 #(
      .W(ADCBI_P_W),
      .RST_VAL(ADCBI_PIN_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .p(pins)
   );

   logic selected;
   logic conv_req;
   logic read_en;
   logic run_cont;
   assign selected = pins.sync[ADCBI_P_SEL] & ~pins.sync[ADCBI_P_EN_N];
   assign run_cont = pins.sync[ADCBI_P_RUN];
   // The strobe only counts in demand mode.
   assign conv_req = selected & ~pins.sync[ADCBI_P_CONV_N] & ~run_cont;
   assign read_en = selected & ~pins.sync[ADCBI_P_OE_N];

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] ctrl_r;
   logic [ADCBI_ST_W-1:0] stat_r;
   logic [ADCBI_ST_W-1:0] mask_r;
   logic [ADCBI_TICK_W-1:0] integ_r;
   logic [14:0] mag_r;
   logic pol_r;
   logic ovr_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic bus_req;
   logic bus_wr;
   logic stat_rd;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign bus_wr = bus_req & wb_we_i;
   assign stat_rd = bus_req & ~wb_we_i & (wb_adr_i == ADCBI_A_STAT);

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // One wait state: the answer comes one edge after the request.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= bus_req;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= ADCBI_CTRL_RST;
         mask_r <= ADCBI_MASK_RST;
         integ_r <= ADCBI_TICK_W'(INTEG_TICKS);
      end
      else if (bus_wr)
      begin
         case (wb_adr_i)
            ADCBI_A_CTRL:
            begin
               ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) &
                  (32'h1 << ADCBI_CTRL_EXTCLK);
            end
            ADCBI_A_MASK:
            begin
               if (wb_sel_i[0])
               begin
                  mask_r <= wb_dat_i[ADCBI_ST_W-1:0];
               end
            end
            ADCBI_A_INTG:
            begin
               integ_r <= ADCBI_TICK_W'(merge(32'(integ_r), wb_dat_i,
                  wb_sel_i));
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdat_r <= 32'h0000_0000;
      end
      else if (bus_req)
      begin
         case (wb_adr_i)
            ADCBI_A_CTRL: rdat_r <= ctrl_r;
            ADCBI_A_STAT: rdat_r <= 32'(stat_r);
            ADCBI_A_MASK: rdat_r <= 32'(mask_r);
            ADCBI_A_RSLT:
            begin
               rdat_r <= 32'(mag_r);
               rdat_r[ADCBI_RS_POL] <= pol_r;
               rdat_r[ADCBI_RS_OVR] <= ovr_r;
               rdat_r[ADCBI_RS_BUSY] <= busy_o;
            end
            ADCBI_A_INTG: rdat_r <= 32'(integ_r);
            default: rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ****************************************************************
   // Conversion clock
   // ****************************************************************
   // With the external source every rising edge of clock_in_pin is one
   // tick; the pin is oversampled, so it must stay well below clk_i/4.
   logic [ADCBI_TICK_W-1:0] div_r;
   logic osc_prev_r;
   logic tick;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r <= '0;
         osc_prev_r <= 1'b0;
      end
      else
      begin
         osc_prev_r <= pins.sync[ADCBI_P_OSC];
         if (div_r == ADCBI_TICK_W'(OSC_DIV - 1))
         begin
            div_r <= '0;
         end
         else
         begin
            div_r <= div_r + 1'b1;
         end
      end
   end

   always_comb
   begin
      if (ctrl_r[ADCBI_CTRL_EXTCLK])
      begin
         tick = pins.sync[ADCBI_P_OSC] & ~osc_prev_r;
      end
      else
      begin
         tick = (div_r == ADCBI_TICK_W'(OSC_DIV - 1));
      end
   end

   // ****************************************************************
   // Conversion sequencer
   // ****************************************************************
   adcbi_state_t state_r;
   logic [ADCBI_TICK_W-1:0] cnt_r;
   logic conv_start;
   logic conv_done;
   logic deint_end;

   assign conv_start = (state_r == ADCBI_IDLE) & (run_cont | conv_req);
   assign deint_end = tick & (core_zero_cross_i |
      (cnt_r == ADCBI_TICK_W'(DEINT_MAX - 1)));
   assign conv_done = (state_r == ADCBI_DEINT) & deint_end;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ADCBI_IDLE;
         cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            ADCBI_IDLE:
            begin
               cnt_r <= '0;
               if (conv_start)
               begin
                  state_r <= ADCBI_INTEG;
               end
            end
            ADCBI_INTEG:
            begin
               if (tick)
               begin
                  if (cnt_r == integ_r - 1'b1 || integ_r == '0)
                  begin
                     cnt_r <= '0;
                     state_r <= ADCBI_DEINT;
                  end
                  else
                  begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            end
            ADCBI_DEINT:
            begin
               if (deint_end)
               begin
                  state_r <= ADCBI_IDLE;
               end
               else if (tick)
               begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            default:
            begin
               state_r <= ADCBI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mag_r <= '0;
         pol_r <= 1'b0;
         ovr_r <= 1'b0;
      end
      else if (conv_done)
      begin
         mag_r <= core_magnitude_i;
         pol_r <= core_polarity_i;
         ovr_r <= core_overrange_i;
      end
   end

   assign busy_o = (state_r == ADCBI_DEINT);
   assign core_integrate_o = (state_r == ADCBI_INTEG);
   assign core_deintegrate_o = (state_r == ADCBI_DEINT);

   // ****************************************************************
   // Interrupt status
   // ****************************************************************
   logic [ADCBI_ST_W-1:0] ev;
   always_comb
   begin
      ev = '0;
      ev[ADCBI_ST_DONE] = conv_done;
      ev[ADCBI_ST_START] = conv_start;
      ev[ADCBI_ST_OVR] = conv_done & core_overrange_i;
   end

   // A new event in the clearing read's own cycle survives the clear.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stat_r <= '0;
      end
      else if (stat_rd)
      begin
         stat_r <= ev;
      end
      else
      begin
         stat_r <= stat_r | ev;
      end
   end

   assign irq_o = |(stat_r & mask_r);

   // ****************************************************************
   // Result bus
   // ****************************************************************
   // Bytes are steered in every mode; the continuous three-byte
   // sequence is not modelled, so reads there follow the same selects.
   logic [6:0] lo_nxt;
   logic msb_nxt;
   logic [6:0] bus_r;
   logic msb_r;
   logic oe_r;

   always_comb
   begin
      if (pins.sync[ADCBI_P_BYTE])
      begin
         lo_nxt = mag_r[6:0];
         msb_nxt = mag_r[7];
      end
      else
      begin
         lo_nxt = mag_r[14:8];
         if (pins.sync[ADCBI_P_FLAG])
         begin
            msb_nxt = ovr_r;
         end
         else
         begin
            msb_nxt = pol_r;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_r <= '0;
         msb_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         bus_r <= lo_nxt;
         msb_r <= msb_nxt;
         oe_r <= read_en;
      end
   end

   assign result_bus_o = bus_r;
   assign result_bus_msb_o = msb_r;
   assign result_bus_oe_o = oe_r;
   assign result_bus_msb_oe_o = oe_r;
endmodule

/* File: tb/adcbi_monitor.sv */
`timescale 1ns/1ns
module adcbi_monitor
#(
   parameter int unsigned OSC_DIV = 4,
   parameter int unsigned DEINT_MAX = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic chip_select_i,
   input wire logic enable_active_low_n_i,
   input wire logic convert_strobe_n_i,
   input wire logic output_enable_n_i,
   input wire logic run_mode_select_i,
   input wire logic result_bus_oe_o,
   input wire logic result_bus_msb_oe_o,
   input wire logic busy_o,
   input wire logic core_integrate_o,
   input wire logic core_deintegrate_o
);
   // A slow oscillator tick can add a few cycles beyond the count.
   localparam int BUSY_MAX = DEINT_MAX * OSC_DIV + 8;
   logic sel;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign sel = chip_select_i & ~enable_active_low_n_i;
   a_oe_follows:
   assert property (result_bus_oe_o ==
      ($past(sel, 3) & !$past(output_enable_n_i, 3)))
      else $error("bus drive enable does not follow selection");
   a_msb_oe_same:
   assert property (result_bus_msb_oe_o == result_bus_oe_o)
      else $error("top line enable differs from lower lines");
   a_busy_is_deint:
   assert property (busy_o == core_deintegrate_o
      && !(busy_o && core_integrate_o))
      else $error("busy differs from the de-integrate phase");
   a_busy_after_integ:
   assert property ($rose(busy_o) |-> $past(core_integrate_o))
      else $error("busy rose without a preceding integrate phase");
   a_busy_bounded:
   assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o)
      else $error("busy stayed high too long");
   a_start_cause:
   assert property ($rose(core_integrate_o) |-> $past(run_mode_select_i, 3)
      || ($past(sel, 3) && !$past(convert_strobe_n_i, 3)))
      else $error("conversion started without a cause");
   a_ack_answers:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("register request not answered next cycle");
   a_ack_single:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_ack_has_req:
   assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without a request");
endmodule

/* File: tb/adcbi_host_model.sv */
`timescale 1ns/1ns
module adcbi_host_model
(
   input wire logic clk_i,
   input wire logic busy_i,
   input wire logic drv_i,
   input wire logic [7:0] data_i,
   output logic cs_o,
   output logic en_n_o,
   output logic conv_n_o,
   output logic rd_n_o,
   output logic run_o,
   output logic flag_o,
   output logic low_o
);
   initial
   begin
      cs_o = 1'h0;
      en_n_o = 1'h1;
      conv_n_o = 1'h1;
      rd_n_o = 1'h1;
      run_o = 1'h0;
      flag_o = 1'h0;
      low_o = 1'h0;
   end
   // The strobe is a level, so it is dropped once busy shows the start.
   task automatic conv(input logic sel, output logic got);
      int i;
      cs_o <= sel;
      en_n_o <= 1'h0;
      conv_n_o <= 1'h0;
      got = 1'h0;
      for (i = 0; i < 40 && !got; i++)
      begin
         @(posedge clk_i);
         got = (busy_i === 1'h1);
      end
      conv_n_o <= 1'h1;
      cs_o <= 1'h0;
      en_n_o <= 1'h1;
      @(posedge clk_i);
   endtask
   task automatic read(input logic en_n, input logic hi, input logic fl,
      output logic [8:0] q);
      cs_o <= 1'h1;
      en_n_o <= en_n;
      low_o <= !hi;
      flag_o <= fl;
      rd_n_o <= 1'h0;
      repeat (4) @(posedge clk_i);
      q = {drv_i, data_i};
      cs_o <= 1'h0;
      en_n_o <= 1'h1;
      rd_n_o <= 1'h1;
      @(posedge clk_i);
   endtask
   task automatic mode(input logic m);
      run_o <= m;
      @(posedge clk_i);
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb
   import adcbi_pkg::*;
   ;
   typedef struct packed {logic [14:0] mag; logic pol; logic ovr;
      logic hi; logic fl; logic [7:0] exp;} adcbi_row_t;
   localparam int unsigned INTG = 3;
   localparam adcbi_row_t ROWS [6] = '{
      '{15'h5A3C, 1'h1, 1'h0, 1'h0, 1'h0, 8'h3C},
      '{15'h5A3C, 1'h1, 1'h0, 1'h1, 1'h0, 8'hDA},
      '{15'h5A3C, 1'h1, 1'h0, 1'h1, 1'h1, 8'h5A},
      '{15'h7F81, 1'h0, 1'h1, 1'h0, 1'h0, 8'h81},
      '{15'h7F81, 1'h0, 1'h1, 1'h1, 1'h1, 8'hFF},
      '{15'h7F81, 1'h0, 1'h1, 1'h1, 1'h0, 8'h7F}};
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, irq_o, busy_o, core_integrate_o, core_deintegrate_o;
   logic chip_select_i, enable_active_low_n_i, convert_strobe_n_i;
   logic output_enable_n_i, run_mode_select_i, flag_byte_select_i;
   logic byte_half_select_i, result_bus_oe_o, result_bus_msb_o;
   logic result_bus_msb_oe_o, core_zero_cross_i, got, b;
   logic [6:0] result_bus_o;
   logic [14:0] mag = 15'h0;
   logic pol = 1'h0;
   logic ovr = 1'h0;
   logic [7:0] zcnt = 8'h00;
   logic [2:0] ocnt = 3'h0;
   logic osc_en = 1'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [8:0] q;
   int error_cnt = 0;
   int n_compared = 0;
   int n;
   always #10 clk_i = ~clk_i;
   // The core model crosses zero five cycles into de-integration.
   always @(posedge clk_i) zcnt <= busy_o ? zcnt + 8'h01 : 8'h00;
   assign core_zero_cross_i = busy_o && (zcnt >= 8'h05);
   // External conversion clock: one rising edge every eight cycles, gated.
   always @(posedge clk_i) ocnt <= ocnt + 3'h1;
   adcbi_top #(.OSC_DIV(4), .INTEG_TICKS(INTG), .DEINT_MAX(8)) dut
   (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
      .chip_select_i, .enable_active_low_n_i, .convert_strobe_n_i,
      .output_enable_n_i, .run_mode_select_i, .flag_byte_select_i,
      .byte_half_select_i, .clock_in_pin_i(ocnt[2] & osc_en),
      .result_bus_o,
      .result_bus_oe_o, .result_bus_msb_o, .result_bus_msb_oe_o, .busy_o,
      .core_integrate_o, .core_deintegrate_o, .core_zero_cross_i,
      .core_magnitude_i(mag), .core_polarity_i(pol), .core_overrange_i(ovr)
   );
   adcbi_host_model u_host
   (
      .clk_i, .busy_i(busy_o), .drv_i(result_bus_oe_o),
      .data_i({result_bus_msb_o, result_bus_o}), .cs_o(chip_select_i),
      .en_n_o(enable_active_low_n_i), .conv_n_o(convert_strobe_n_i),
      .rd_n_o(output_enable_n_i), .run_o(run_mode_select_i),
      .flag_o(flag_byte_select_i), .low_o(byte_half_select_i)
   );
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic expire;
      error_cnt++;
      $display("CHECK FAILED t=%0t wait expired", $time);
      finish_test();
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_i);
         if (wb_ack_o === 1'h1)
            break;
      end
      if (i == 20)
         expire();
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 100; i++)
      begin
         @(posedge clk_i);
         if ((busy_o | core_integrate_o) === 1'h0)
            break;
      end
      if (i == 100)
         expire();
   endtask
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      wb(1'h0, ADCBI_A_CTRL, 32'h0);
      check(rd, ADCBI_CTRL_RST);
      wb(1'h0, ADCBI_A_MASK, 32'h0);
      check(rd, {29'h0, ADCBI_MASK_RST});
      wb(1'h0, ADCBI_A_INTG, 32'h0);
      check(rd, INTG);
      wb(1'h1, 8'h40, 32'hFFFFFFFF);
      wb(1'h0, 8'h40, 32'h0);
      check(rd, 32'h0);
      check({irq_o, busy_o, result_bus_oe_o}, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 6; k++)
      begin
         mag <= ROWS[k].mag;
         pol <= ROWS[k].pol;
         ovr <= ROWS[k].ovr;
         u_host.conv(1'h1, got);
         check(got, 32'h1);
         wait_idle();
         u_host.read(1'h0, ROWS[k].hi, ROWS[k].fl, q);
         check(q, {1'h1, ROWS[k].exp});
      end
      $display("test rows done");
      check(irq_o, 32'h0);
      wb(1'h0, ADCBI_A_STAT, 32'h0);
      check(rd[ADCBI_ST_DONE], 32'h1);
      wb(1'h0, ADCBI_A_STAT, 32'h0);
      check(rd, 32'h0);
      wb(1'h1, ADCBI_A_MASK, 32'h1);
      u_host.conv(1'h1, got);
      wait_idle();
      check(irq_o, 32'h1);
      wb(1'h0, ADCBI_A_STAT, 32'h0);
      @(posedge clk_i);
      check(irq_o, 32'h0);
      wb_sel_i <= 4'h2;
      wb(1'h1, ADCBI_A_MASK, 32'h0);
      wb_sel_i <= 4'hF;
      wb(1'h0, ADCBI_A_MASK, 32'h0);
      check(rd, 32'h1);
      $display("test irq done");
      u_host.conv(1'h0, got);
      check(got, 32'h0);
      u_host.read(1'h1, 1'h0, 1'h0, q);
      check(q[8], 32'h0);
      $display("test deselect done");
      wb(1'h1, ADCBI_A_CTRL, 32'h1 << ADCBI_CTRL_EXTCLK);
      wb(1'h0, ADCBI_A_CTRL, 32'h0);
      check(rd, 32'h1 << ADCBI_CTRL_EXTCLK);
      // With the pin held still the conversion must stall in integration.
      u_host.conv(1'h1, got);
      check(got, 32'h0);
      osc_en <= 1'h1;
      wait_idle();
      wb(1'h0, ADCBI_A_STAT, 32'h0);
      check(rd[ADCBI_ST_DONE], 32'h1);
      wb(1'h1, ADCBI_A_CTRL, 32'h0);
      $display("test external clock done");
      u_host.mode(1'h1);
      n = 0;
      b = 1'h0;
      repeat (300)
      begin
         @(posedge clk_i);
         if (b && busy_o === 1'h0)
            n++;
         b = busy_o;
      end
      check(n >= 4, 32'h1);
      u_host.mode(1'h0);
      repeat (5) @(posedge clk_i);
      wait_idle();
      n = 0;
      repeat (60)
      begin
         @(posedge clk_i);
         if (busy_o !== 1'h0)
            n++;
      end
      check(n, 32'h0);
      $display("test modes done");
      wb(1'h1, ADCBI_A_INTG, 32'h5);
      u_host.conv(1'h1, got);
      check(got, 32'h1);
      // Reset lands in the middle of de-integration.
      rst_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      check({irq_o, busy_o, core_integrate_o, wb_ack_o}, 32'h0);
      @(posedge clk_i);
      check({busy_o, core_integrate_o, result_bus_oe_o}, 32'h0);
      wb(1'h0, ADCBI_A_INTG, 32'h0);
      check(rd, INTG);
      wb(1'h0, ADCBI_A_MASK, 32'h0);
      check(rd, {29'h0, ADCBI_MASK_RST});
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
bind adcbi_top adcbi_monitor #(.OSC_DIV(OSC_DIV), .DEINT_MAX(DEINT_MAX)) u_mon
(
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .chip_select_i,
   .enable_active_low_n_i, .convert_strobe_n_i, .output_enable_n_i,
   .run_mode_select_i, .result_bus_oe_o, .result_bus_msb_oe_o, .busy_o,
   .core_integrate_o, .core_deintegrate_o
);
